// ==== rtl/cmd_seq_defines.vh ====
// Constants for the direct command sequencer
`ifndef CMD_SEQ_DEFINES_VH
`define CMD_SEQ_DEFINES_VH
`define CLK_MHZ        100
`define CMD_MASK_RX    4'h1
`define CMD_UNMASK_RX  4'h2
`define CMD_MEAS_AMP   4'h3
`define CMD_SQUELCH    4'h4
`define CMD_RESET_GAIN 4'h5
`define CMD_ADJ_REG    4'h6
`define CMD_CAL_MOD    4'h7
`define CMD_CAL_ANT    4'h8
`define CMD_MEAS_PHASE 4'h9
`define CMD_CLR_RSSI   4'ha
`define CMD_TRANSP     4'hb
`define ADDR_CTRL      3'h0
`define ADDR_ADC       3'h1
`define ADDR_RSSI      3'h2
`define ADDR_MOD       3'h3
`define ADDR_GAIN      3'h4
`define ADDR_REG       3'h5
`define ADDR_STAT      3'h6
`define ADDR_TRIM      3'h7
`define OSC_EN_BIT     7
`define RX_EN_BIT      6
`define TX_EN_BIT      3
`define REG_EXT_BIT    7
`define T_MEAS_US      25
`define T_SQUELCH_US   500
`define T_REG_STEP_US  300
`define T_CAL_MOD_US   275
`define T_CAL_ANT_US   250
`define T_REG_MAX_US   5000
`define MARGIN_MV      250
`define REG_MAX_SET    5'h1f
`define REG_MIN_SET    5'h00
`define CTRL_RESET     8'h00
`define MOD_RESET      8'h00
`endif

// ==== rtl/direct_cmd_seq.v ====
// Direct command sequencer for the reader receiver and calibration logic
`timescale 1ns/1ps
`include "cmd_seq_defines.vh"
module direct_cmd_seq #(
  parameter REG_STEP_CYC = `T_REG_STEP_US * `CLK_MHZ,
  parameter REG_MAX_CYC  = `T_REG_MAX_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Register port
  input  wire [2:0] addr,
  input  wire [7:0] wrData,
  input  wire       wrStrobe,
  input  wire       rdStrobe,
  output reg  [7:0] rdData,
  // Direct command from serial interface
  input  wire [3:0] cmdCode,
  input  wire       cmdStrobe,
  // Analog status pins
  input  wire       oscStablePin,
  input  wire       slaveSelectPin,
  input  wire       maskTimerPin,
  input  wire [7:0] adcPin,
  input  wire       supplyMarginPin,
  input  wire [7:0] rssiPin,
  input  wire       antResonantPin,
  // Analog control
  output reg        rxActive,
  output reg        framingEnable,
  output reg        maskTimerReset,
  output reg        txOn,
  output reg        rxOn,
  output reg        ampDetOn,
  output reg        phaseDetOn,
  output reg        adcRelative,
  output reg        squelchRun,
  output reg        gainInit,
  output reg  [4:0] regSetting,
  output reg  [7:0] antenna_trim_pins,
  output reg  [7:0] modDepth,
  output reg        transparent,
  output reg        cmdDoneIrq,
  output reg        busy
);
  localparam MEAS_CYC    = `T_MEAS_US * `CLK_MHZ;
  localparam SQUELCH_CYC = `T_SQUELCH_US * `CLK_MHZ;
  localparam CALMOD_CYC  = `T_CAL_MOD_US * `CLK_MHZ;
  localparam CALANT_CYC  = `T_CAL_ANT_US * `CLK_MHZ;
  localparam S_IDLE  = 3'd0;
  localparam S_AMP   = 3'd1;
  localparam S_PHASE = 3'd2;
  localparam S_SQL   = 3'd3;
  localparam S_REG   = 3'd4;
  localparam S_MOD   = 3'd5;
  localparam S_ANT   = 3'd6;

  // Two-stage synchronisers for pins
  reg [4:0]  syncA_reg;
  reg [4:0]  syncB_reg;
  reg [7:0]  adcA_reg;
  reg [7:0]  adcB_reg;
  reg [7:0]  rssiA_reg;
  reg [7:0]  rssiB_reg;
  wire       oscStable    = syncB_reg[0];
  wire       ssHigh       = syncB_reg[1];
  wire       timerMask    = syncB_reg[2];
  wire       marginOk     = syncB_reg[3];
  wire       antResonant  = syncB_reg[4];

  reg [7:0]  ctrl_reg;
  reg [7:0]  adc_reg;
  reg [7:0]  rssi_reg;
  reg [7:0]  gain_reg;
  reg [7:0]  regCtrl_reg;
  reg        cmdMask_reg;
  reg        ssPrev_reg;
  reg        transpArm_reg;
  reg        rxPrev_reg;
  reg [2:0]  state_reg;
  reg [19:0] timer_reg;
  reg [19:0] total_reg;

  wire oscOk    = ctrl_reg[`OSC_EN_BIT] & oscStable;
  wire rxEn     = ctrl_reg[`RX_EN_BIT];
  wire txEn     = ctrl_reg[`TX_EN_BIT];
  wire idle     = (state_reg == S_IDLE);
  wire rxActNow = ~(cmdMask_reg | timerMask);

  // Saturating counter step shared by the sequences
  function [19:0] countDown;
    input [19:0] v;
    begin
      countDown = (v == 20'h00000) ? 20'h00000 : v - 20'h00001;
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
      adcA_reg  <= 8'h00;
      adcB_reg  <= 8'h00;
      rssiA_reg <= 8'h00;
      rssiB_reg <= 8'h00;
    end else begin
      syncA_reg <= {antResonantPin, supplyMarginPin, maskTimerPin,
                    slaveSelectPin, oscStablePin};
      syncB_reg <= syncA_reg;
      adcA_reg  <= adcPin;
      adcB_reg  <= adcA_reg;
      rssiA_reg <= rssiPin;
      rssiB_reg <= rssiA_reg;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ctrl_reg       <= `CTRL_RESET;
      adc_reg        <= 8'h00;
      rssi_reg       <= 8'h00;
      gain_reg       <= 8'h00;
      regCtrl_reg    <= 8'h00;
      modDepth       <= `MOD_RESET;
      cmdMask_reg    <= 1'b0;
      ssPrev_reg     <= 1'b0;
      transpArm_reg  <= 1'b0;
      rxPrev_reg     <= 1'b0;
      state_reg      <= S_IDLE;
      timer_reg      <= 20'h00000;
      total_reg      <= 20'h00000;
      rdData         <= 8'h00;
      rxActive       <= 1'b0;
      framingEnable  <= 1'b0;
      maskTimerReset <= 1'b0;
      txOn           <= 1'b0;
      rxOn           <= 1'b0;
      ampDetOn       <= 1'b0;
      phaseDetOn     <= 1'b0;
      adcRelative    <= 1'b0;
      squelchRun     <= 1'b0;
      gainInit       <= 1'b0;
      regSetting     <= `REG_MAX_SET;
      antenna_trim_pins <= 8'h00;
      transparent    <= 1'b0;
      cmdDoneIrq     <= 1'b0;
      busy           <= 1'b0;
    end else begin
      maskTimerReset <= 1'b0;
      gainInit       <= 1'b0;
      cmdDoneIrq     <= 1'b0;
      ssPrev_reg     <= ssHigh;
      rxPrev_reg     <= rxActNow;
      // NOR of command mask and timer mask, gated by rx enable
      rxActive      <= rxActNow & rxEn;
      framingEnable <= rxActNow & rxEn;
      // Rising NOR of the two masks, before rx enable gating, clears RSSI; peak hold while unmasked
      if (rxActNow & ~rxPrev_reg)
        rssi_reg <= 8'h00;
      else if (rxActNow & (rssiB_reg > rssi_reg))
        rssi_reg <= rssiB_reg;
      // Enter on select rise, hold while high
      if (~ssHigh)
        transparent <= 1'b0;
      else if (~ssPrev_reg & transpArm_reg) begin
        transparent   <= 1'b1;
        transpArm_reg <= 1'b0;
      end
      // Register port; reads answer in the following cycle
      rdData <= 8'h00;
      if (rdStrobe) begin
        case (addr)
          `ADDR_CTRL: rdData <= ctrl_reg;
          `ADDR_ADC:  rdData <= adc_reg;
          `ADDR_RSSI: rdData <= rssi_reg;
          `ADDR_MOD:  rdData <= modDepth;
          `ADDR_GAIN: rdData <= gain_reg;
          `ADDR_REG:  rdData <= regCtrl_reg;
          `ADDR_STAT: rdData <= {busy, transparent, rxActive, oscStable,
                                 regSetting[3:0]};
          `ADDR_TRIM: rdData <= antenna_trim_pins;
          default:    rdData <= 8'h00;
        endcase
      end
      if (wrStrobe) begin
        case (addr)
          `ADDR_CTRL: ctrl_reg    <= wrData;
          `ADDR_MOD:  modDepth    <= wrData;
          `ADDR_GAIN: gain_reg    <= wrData;
          `ADDR_REG:  regCtrl_reg <= wrData;
          default:    ctrl_reg    <= ctrl_reg;
        endcase
      end
      // Command decode; commands outside their conditions are dropped
      // Unaccepted commands leave everything unchanged
      if (cmdStrobe) begin
        case (cmdCode)
          // Mask commands gated by rx enable
          `CMD_MASK_RX: if (rxEn) cmdMask_reg <= 1'b1;
          `CMD_UNMASK_RX: if (rxEn) begin
            cmdMask_reg <= 1'b0;
            if (timerMask)
              maskTimerReset <= 1'b1;
          end
          `CMD_MEAS_AMP: if (oscOk & idle) begin
            state_reg <= S_AMP;
            timer_reg <= MEAS_CYC[19:0];
          end
          `CMD_MEAS_PHASE: if (oscOk & idle) begin
            state_reg <= S_PHASE;
            timer_reg <= MEAS_CYC[19:0];
          end
          // Squelch needs tx and rx, runs only when masked
          `CMD_SQUELCH: if (txEn & rxEn & idle & ~rxActive) begin
            state_reg  <= S_SQL;
            timer_reg  <= SQUELCH_CYC[19:0];
            squelchRun <= 1'b1;
          end
          // Abort squelch and reload manual gain
          `CMD_RESET_GAIN: if (oscOk) begin
            gainInit   <= 1'b1;
            squelchRun <= 1'b0;
            rssi_reg   <= 8'h00;
            if (state_reg == S_SQL) begin
              state_reg <= S_IDLE;
              busy      <= 1'b0;
            end
          end
          `CMD_ADJ_REG: if (oscOk & idle & ~regCtrl_reg[`REG_EXT_BIT]) begin
            state_reg  <= S_REG;
            timer_reg  <= REG_STEP_CYC[19:0];
            total_reg  <= REG_MAX_CYC[19:0];
            regSetting <= `REG_MAX_SET;
          end
          `CMD_CAL_MOD: if (oscOk & idle) begin
            state_reg <= S_MOD;
            timer_reg <= CALMOD_CYC[19:0];
          end
          `CMD_CAL_ANT: if (oscOk & idle) begin
            state_reg <= S_ANT;
            timer_reg <= CALANT_CYC[19:0];
            antenna_trim_pins <= 8'h00;
          end
          // Clear RSSI and restart peak hold
          `CMD_CLR_RSSI: if (oscOk) rssi_reg <= 8'h00;
          `CMD_TRANSP: if (oscOk) transpArm_reg <= 1'b1;
          default: transpArm_reg <= transpArm_reg;
        endcase
      end
      // Sequence execution
      case (state_reg)
        S_IDLE: begin
          busy <= 1'b0;
          txOn <= 1'b0;
          rxOn <= 1'b0;
          ampDetOn <= 1'b0;
          phaseDetOn <= 1'b0;
          adcRelative <= 1'b0;
        end
        S_AMP: begin
          busy <= 1'b1;
          txOn <= 1'b1;
          ampDetOn <= 1'b1;
          adcRelative <= 1'b0;
          timer_reg <= countDown(timer_reg);
          if (timer_reg == 20'h00001) begin
            adc_reg    <= adcB_reg;
            state_reg  <= S_IDLE;
            cmdDoneIrq <= 1'b1;
          end
        end
        // Converter range clips to ff and 00
        // Code 80 is ninety degrees, higher is less
        S_PHASE: begin
          busy <= 1'b1;
          txOn <= 1'b1;
          phaseDetOn <= 1'b1;
          adcRelative <= 1'b1;
          timer_reg <= countDown(timer_reg);
          if (timer_reg == 20'h00001) begin
            adc_reg    <= adcB_reg;
            state_reg  <= S_IDLE;
            cmdDoneIrq <= 1'b1;
          end
        end
        // Squelch ends silently
        S_SQL: begin
          busy <= 1'b1;
          timer_reg <= countDown(timer_reg);
          if (timer_reg == 20'h00001) begin
            squelchRun <= 1'b0;
            state_reg  <= S_IDLE;
          end
        end
        // Step down each interval while margin is short
        S_REG: begin
          busy <= 1'b1;
          txOn <= 1'b1;
          rxOn <= 1'b1;
          timer_reg <= countDown(timer_reg);
          total_reg <= countDown(total_reg);
          if (timer_reg == 20'h00001) begin
            if (marginOk | (regSetting == `REG_MIN_SET) |
                (total_reg < REG_STEP_CYC[19:0])) begin
              state_reg  <= S_IDLE;
              cmdDoneIrq <= 1'b1;
            end else begin
              regSetting <= regSetting - 5'h01;
              timer_reg  <= REG_STEP_CYC[19:0];
            end
          end
        end
        // Move toward target, result written back
        S_MOD: begin
          busy <= 1'b1;
          txOn <= 1'b1;
          timer_reg <= countDown(timer_reg);
          if (timer_reg[7:0] == 8'h00) begin
            if (adcB_reg > modDepth)
              modDepth <= modDepth + 8'h01;
            else if (adcB_reg < modDepth)
              modDepth <= modDepth - 8'h01;
          end
          if (timer_reg == 20'h00001) begin
            state_reg  <= S_IDLE;
            cmdDoneIrq <= 1'b1;
          end
        end
        S_ANT: begin
          busy <= 1'b1;
          txOn <= 1'b1;
          timer_reg <= countDown(timer_reg);
          if (timer_reg[6:0] == 7'h00 & ~antResonant)
            antenna_trim_pins <= antenna_trim_pins + 8'h01;
          if (timer_reg == 20'h00001) begin
            state_reg  <= S_IDLE;
            cmdDoneIrq <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/afe_model.sv ====
// Analog front end stand-in that drives the sequencer status pins except slave select, which the bench drives
`timescale 1ns/1ps
module afe_model #(
  parameter [7:0] AMP_CODE   = 8'h5a,
  parameter [7:0] PHASE_CODE = 8'hff,
  parameter [4:0] MARGIN_SET = 5'h1c,
  parameter [7:0] TRIM_HIT   = 8'h05,
  parameter [7:0] MOD_CODE   = 8'h50
) (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Controls
  input  wire       timerStart,
  input  wire       maskTimerReset,
  input  wire       txOn,
  input  wire       ampDetOn,
  input  wire       phaseDetOn,
  input  wire [4:0] regSetting,
  input  wire [7:0] antenna_trim_pins,
  // Status pins
  output reg        oscStablePin,
  output wire       maskTimerPin,
  output wire [7:0] adcPin,
  output wire       supplyMarginPin,
  output wire [7:0] rssiPin,
  output wire       antResonantPin
);
  reg [7:0] tick_reg;
  reg       timer_reg;
  always @(posedge clk) begin
    tick_reg     <= reset ? 8'h00 : tick_reg + 8'h01;
    oscStablePin <= !reset && (oscStablePin || tick_reg[4]);
    timer_reg    <= !reset && (timerStart || (timer_reg && !maskTimerReset));
  end
  // Timer drops at once on maskTimerReset so no stale mask lingers
  assign maskTimerPin    = timer_reg & !maskTimerReset;
  // Idle converter output keeps changing, never a stale value
  // Carrier on without a detector reports the measured modulation depth
  assign adcPin          = ampDetOn ? AMP_CODE : phaseDetOn ? PHASE_CODE :
                           txOn ? MOD_CODE : tick_reg;
  assign supplyMarginPin = regSetting <= MARGIN_SET;
  assign rssiPin         = tick_reg;
  assign antResonantPin  = antenna_trim_pins >= TRIM_HIT;
endmodule

// ==== tb/cmd_seq_properties.sv ====
// Port-level assertions for the direct command sequencer
`timescale 1ns/1ps
`include "cmd_seq_defines.vh"
module cmd_seq_checker (
  // Clock, reset and host side
  input wire       clk, reset, wrStrobe, cmdStrobe,
  input wire [2:0] addr,
  input wire [7:0] wrData,
  input wire [3:0] cmdCode,
  // Status pins
  input wire       oscStablePin, slaveSelectPin, maskTimerPin,
  // Sequencer outputs
  input wire       rxActive, txOn, rxOn, ampDetOn, phaseDetOn, adcRelative,
  input wire       transparent, cmdDoneIrq, busy,
  input wire [4:0] regSetting
);
  reg  [7:0]  ctrl_reg;
  reg         regExt_reg;
  reg  [11:0] measCnt_reg;
  // Raw oscillator pin is fine here: the bench only enables after it settles
  wire        oscOk = ctrl_reg[`OSC_EN_BIT] & oscStablePin & !busy;
  wire        isMeas = txOn & (ampDetOn | phaseDetOn);
  always @(posedge clk) begin
    if (reset) begin
      ctrl_reg    <= 8'h00;
      regExt_reg  <= 1'b0;
      measCnt_reg <= 12'h000;
    end else begin
      if (wrStrobe && addr == `ADDR_CTRL)
        ctrl_reg <= wrData;
      if (wrStrobe && addr == `ADDR_REG)
        regExt_reg <= wrData[`REG_EXT_BIT];
      measCnt_reg <= isMeas ? measCnt_reg + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_mask;
    cmdStrobe && cmdCode == `CMD_MASK_RX && ctrl_reg[`RX_EN_BIT] |-> ##[1:4] !rxActive;
  endproperty
  a_mask: assert property (p_mask) else $error("mask left receiver active");
  property p_timer;
    $rose(maskTimerPin) ##1 maskTimerPin [*4] |-> !rxActive;
  endproperty
  a_timer: assert property (p_timer) else $error("timer mask ignored");
  property p_amp;
    cmdStrobe && cmdCode == `CMD_MEAS_AMP && oscOk |-> ##2 txOn && ampDetOn && !adcRelative;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude path not set");
  property p_meas_time;
    isMeas |-> measCnt_reg < 12'h9c4;
  endproperty
  a_meas_time: assert property (p_meas_time) else $error("measurement too long");
  property p_phase;
    cmdStrobe && cmdCode == `CMD_MEAS_PHASE && oscOk |-> ##2 txOn && phaseDetOn && adcRelative;
  endproperty
  a_phase: assert property (p_phase) else $error("phase path not set");
  property p_reg_start;
    cmdStrobe && cmdCode == `CMD_ADJ_REG && oscOk && !regExt_reg |-> ##2
      txOn && rxOn && regSetting == `REG_MAX_SET;
  endproperty
  a_reg_start: assert property (p_reg_start) else $error("regulator start wrong");
  property p_reg_step;
    regSetting < $past(regSetting) |-> $past(regSetting) == regSetting + 5'h01;
  endproperty
  a_reg_step: assert property (p_reg_step) else $error("regulator step not one");
  property p_reg_ext;
    cmdStrobe && cmdCode == `CMD_ADJ_REG && oscOk && regExt_reg |-> ##1 !busy [*3];
  endproperty
  a_reg_ext: assert property (p_reg_ext) else $error("external regulator not refused");
  property p_ignored;
    cmdStrobe && !ctrl_reg[`OSC_EN_BIT] && !busy &&
      (cmdCode == `CMD_MEAS_AMP || cmdCode == `CMD_MEAS_PHASE) |=> (!busy && !cmdDoneIrq) [*3];
  endproperty
  a_ignored: assert property (p_ignored) else $error("command ran without oscillator");
  property p_transp;
    !slaveSelectPin [*5] |-> !transparent;
  endproperty
  a_transp: assert property (p_transp) else $error("transparent with select low");
endmodule
bind direct_cmd_seq cmd_seq_checker u_chk (.clk, .reset, .wrStrobe, .cmdStrobe, .addr, .wrData,
  .cmdCode, .oscStablePin, .slaveSelectPin, .maskTimerPin, .rxActive, .txOn, .rxOn, .ampDetOn,
  .phaseDetOn, .adcRelative, .transparent, .cmdDoneIrq, .busy, .regSetting);

// ==== tb/testbench.sv ====
// Self-checking bench for the direct command sequencer
`timescale 1ns/1ps
`include "cmd_seq_defines.vh"
module testbench;
  reg        clk, reset, wrStrobe, rdStrobe, cmdStrobe, slaveSelectPin, timerStart;
  reg        pulseSeen, irqSeen, gainSeen;
  reg  [2:0] addr;
  reg  [7:0] wrData;
  reg  [3:0] cmdCode;
  wire [7:0] rdData, adcPin, rssiPin, antenna_trim_pins, modDepth;
  wire [4:0] regSetting;
  wire       oscStablePin, maskTimerPin, supplyMarginPin, antResonantPin, rxActive;
  wire       framingEnable, maskTimerReset, txOn, rxOn, ampDetOn, phaseDetOn, adcRelative;
  wire       squelchRun, gainInit, transparent, cmdDoneIrq, busy;
  integer    error_cnt, checks, n;
  // Short regulator counts keep the run brief
  direct_cmd_seq #(.REG_STEP_CYC(30), .REG_MAX_CYC(500)) u_dut (.clk, .reset, .addr, .wrData,
    .wrStrobe, .rdStrobe, .rdData, .cmdCode, .cmdStrobe, .oscStablePin, .slaveSelectPin,
    .maskTimerPin, .adcPin, .supplyMarginPin, .rssiPin, .antResonantPin, .rxActive,
    .framingEnable, .maskTimerReset, .txOn, .rxOn, .ampDetOn, .phaseDetOn, .adcRelative,
    .squelchRun, .gainInit, .regSetting, .antenna_trim_pins, .modDepth, .transparent,
    .cmdDoneIrq, .busy);
  afe_model u_afe (.clk, .reset, .timerStart, .maskTimerReset, .txOn, .ampDetOn, .phaseDetOn,
    .regSetting, .antenna_trim_pins, .oscStablePin, .maskTimerPin, .adcPin,
    .supplyMarginPin, .rssiPin, .antResonantPin);
  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp, input string msg);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a; wrData <= d; wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] e, input string msg);
    begin
      @(posedge clk);
      addr <= a; rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 chk(rdData, e, msg);
    end
  endtask
  task cmd(input [3:0] c);
    begin
      @(posedge clk);
      cmdCode <= c; cmdStrobe <= 1'b1;
      @(posedge clk);
      cmdStrobe <= 1'b0;
      #1;
    end
  endtask
  // Samples on the falling edge so one-cycle pulses are never missed
  task wt(input integer k);
    repeat (k) begin
      @(negedge clk);
      pulseSeen = pulseSeen | maskTimerReset;
      irqSeen = irqSeen | cmdDoneIrq;
      gainSeen = gainSeen | gainInit;
    end
  endtask
  task wait_irq(input integer lim);
    begin
      n = 0;
      while (cmdDoneIrq !== 1'b1 && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= lim) begin
        chk(1'b0, 1'b1, "completion late");
        finish_test;
      end
    end
  endtask
  task t_mask;
    begin
      cmd(`CMD_MASK_RX); wr(`ADDR_CTRL, 8'h40); irqSeen = 0;
      wt(4); chk(rxActive, 1'b1, "mask while rx off");
      cmd(`CMD_UNMASK_RX); wt(4); chk(framingEnable, 1'b1, "unmask framing");
      cmd(`CMD_MASK_RX); wt(4); chk(rxActive, 1'b0, "mask");
      chk(framingEnable, 1'b0, "mask framing");
      cmd(`CMD_UNMASK_RX); wt(4);
      @(posedge clk) timerStart <= 1'b1;
      @(posedge clk) timerStart <= 1'b0;
      wt(5); chk(rxActive, 1'b0, "timer mask");
      pulseSeen = 0;
      cmd(`CMD_UNMASK_RX); wt(5); chk(pulseSeen, 1'b1, "timer reset");
      chk(rxActive, 1'b1, "unmask over timer");
      chk(irqSeen, 1'b0, "mask commands irq");
    end
  endtask
  task t_meas(input [3:0] c, input rel, input [7:0] e);
    begin
      cmd(c);
      @(posedge clk) #1 chk(adcRelative, rel, "converter mode");
      wait_irq(2502);
      rd(`ADDR_ADC, e, "converter result");
    end
  endtask
  task t_seq;
    begin
      wr(`ADDR_CTRL, 8'h40);
      cmd(`CMD_MEAS_AMP); wt(4); chk(busy, 1'b0, "no oscillator");
      wr(`ADDR_CTRL, 8'hc0);
      t_meas(`CMD_MEAS_AMP, 1'b0, 8'h5a);
      t_meas(`CMD_MEAS_PHASE, 1'b1, 8'hff);
      wr(`ADDR_REG, 8'h80);
      cmd(`CMD_ADJ_REG); wt(4); chk(busy, 1'b0, "external regulator");
      wr(`ADDR_REG, 8'h00);
      cmd(`CMD_ADJ_REG); chk(regSetting, 8'h1f, "regulator start");
      wait_irq(502);
      chk(regSetting, 8'h1c, "regulator final");
      cmd(`CMD_ADJ_REG); chk(regSetting, 8'h1f, "regulator restart");
      wait_irq(502);
      cmd(`CMD_CAL_ANT); wait_irq(25002);
      rd(`ADDR_TRIM, 8'h05, "trim result");
      wr(`ADDR_MOD, 8'h40);
      cmd(`CMD_CAL_MOD); wait_irq(27502);
      rd(`ADDR_MOD, 8'h50, "modulation result");
    end
  endtask
  task t_squelch;
    begin
      wr(`ADDR_CTRL, 8'hc8); wt(4); irqSeen = 0; gainSeen = 0;
      cmd(`CMD_SQUELCH); wt(2); chk(squelchRun, 1'b0, "squelch rx active");
      cmd(`CMD_MASK_RX); wt(4);
      rd(`ADDR_RSSI, 8'hff, "rssi peak hold");
      cmd(`CMD_CLR_RSSI); rd(`ADDR_RSSI, 8'h00, "rssi clear");
      cmd(`CMD_SQUELCH); wt(10); chk(squelchRun, 1'b1, "squelch start");
      cmd(`CMD_RESET_GAIN); wt(4); chk(squelchRun, 1'b0, "squelch abort");
      chk(gainSeen, 1'b1, "gain init");
      cmd(`CMD_CLR_RSSI); wt(4); chk(irqSeen, 1'b0, "no irq");
      cmd(`CMD_TRANSP);
      @(posedge clk) slaveSelectPin <= 1'b1;
      wt(6); chk(transparent, 1'b1, "transparent entry");
      @(posedge clk) slaveSelectPin <= 1'b0;
      wt(6); chk(transparent, 1'b0, "transparent exit");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset = 1'b1; wrStrobe = 0; rdStrobe = 0; cmdStrobe = 0; slaveSelectPin = 0;
    timerStart = 0; addr = 0; wrData = 0; cmdCode = 0; error_cnt = 0; checks = 0;
    pulseSeen = 0; irqSeen = 0; gainSeen = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (30) @(posedge clk);
    #1 chk(regSetting, 8'h1f, "regulator reset value");
    t_mask; $display("mask test done");
    t_seq; $display("sequence test done");
    t_squelch; $display("squelch test done");
    finish_test;
  end
endmodule
